// file: ims_pkg.sv
// Constants, register map and state type for the two-wire serial controller.
// Assumes one 100 MHz clock and a synchronous active-high reset.
// Behaviour
// - While disabled, both line pins are plain general-purpose port pins.
// - Whole bytes handled alone in four roles: master or slave, transmit or receive.
// - Byte transport, clocking, address match and arbitration all done in hardware.
// - Received address bytes compared with own address by hardware.
// - Enable bit 6 low disables the controller; its line drivers float.
// - Begin request bit 5 gives START when bus free, repeated START as master.
// - Halt request bit 4 makes a STOP; hardware clears it on a bus STOP.
// - STOP begins once the event flag is cleared while halt request is set.
// - Address-received bit 3 set by hardware, cleared only by software.
// - Ack enable bit 2 pulls data low in acknowledge slot of received bytes.
// - Ack enable clear leaves data released high in the acknowledge slot.
// - Rate code bits 7,1,0 pick divisor 16,24,30,60,120,240,480,960.
// - Event flag set after own address, general call, master or slave byte, slave stop.
// - Reading the status register clears the event flag.
// - Shift buffer moves bit 7 first, shifting toward the high end.
// - Own id register holds the 7-bit slave address answered to.
package ims_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_STAT = 3'h1;
	localparam logic [2:0] REG_DATA = 3'h2;
	localparam logic [2:0] REG_OWN = 3'h3;
	localparam logic [2:0] REG_ISTAT = 3'h4;
	localparam logic [2:0] REG_IMASK = 3'h5;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	localparam logic [1:0] LINE_IDLE = 2'h3;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CB_RATE_HI = 7;
	localparam int CB_EN = 6;
	localparam int CB_BEGIN = 5;
	localparam int CB_HALT = 4;
	localparam int CB_ADDR = 3;
	localparam int CB_ACK = 2;
	localparam int CB_RATE_MID = 1;
	localparam int CB_RATE_LO = 0;
	localparam int OWN_GC = 0;
	localparam int IB_BYTE = 0;
	localparam int IB_ADDR = 1;
	localparam int IB_STOP = 2;
	localparam int IB_LOST = 3;
	// Bit slot counts within a byte
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_DONE = 4'h9;
	localparam logic [3:0] BIT_PRE = 4'hF;
	// Oscillator divisors 16,24,30,60,120,240,480,960
	localparam logic [9:0] OSC_DIV [8] = '{10'h010, 10'h018, 10'h01E, 10'h03C,
		10'h078, 10'h0F0, 10'h1E0, 10'h3C0};
	// Half a serial clock period in oscillator cycles
	function automatic logic [8:0] half_period(input logic [2:0] code);
		return OSC_DIV[code][9:1];
	endfunction : half_period
	typedef enum logic [3:0] {ST_IDLE, ST_MSTART, ST_MLO, ST_MHI, ST_MWAIT, ST_MRS1,
		ST_MRS2, ST_MSTOP1, ST_MSTOP2, ST_MSTOP3, ST_SBIT, ST_SWAIT, ST_SSKIP} ims_state_type;
endpackage : ims_pkg

// file: ims_line_if.sv
// Synchronised line levels and bus conditions passed to the controller core.
// Assumes the sense module drives every signal on the core clock.
`timescale 1ns/10ps
interface ims_line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	modport sense (output scl, output sda, output scl_rise, output scl_fall,
		output start_det, output stop_det);
	modport core (input scl, input sda, input scl_rise, input scl_fall,
		input start_det, input stop_det);
endinterface : ims_line_if

// file: ims_line_sense.sv
// Two-flop synchronisers and edge / START / STOP detection on the line pins.
// Assumes raw pin levels from outside the clock domain.
`timescale 1ns/10ps
module ims_line_sense (
	input logic clk,
	input logic srst,
	input logic scl_pin,
	input logic sda_pin,
	ims_line_if.sense ln
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_prev;
	logic sda_prev;

	// Synchronisers, idle high like a pulled-up line
	always_ff @(posedge clk) begin
		if (srst) begin
			scl_sync <= ims_pkg::LINE_IDLE;
			sda_sync <= ims_pkg::LINE_IDLE;
		end else begin
			scl_sync <= {scl_sync[0], scl_pin};
			sda_sync <= {sda_sync[0], sda_pin};
		end
	end

	// Previous settled levels for edge finding
	always_ff @(posedge clk) begin
		if (srst) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
		end
	end

	// Data moving while clock stays high marks START or STOP
	assign ln.scl = scl_sync[1];
	assign ln.sda = sda_sync[1];
	assign ln.scl_rise = scl_sync[1] && !scl_prev;
	assign ln.scl_fall = !scl_sync[1] && scl_prev;
	assign ln.start_det = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
	assign ln.stop_det = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_start_sense: assert property (
		ln.start_det |-> $past(ln.sda) && !ln.sda && ln.scl && $past(ln.scl))
		else $error("start seen without falling data under high clock");
endmodule : ims_line_sense

// file: ims_controller.sv
// Two-wire serial controller: master and slave, transmit and receive.
// Assumes open-drain lines with pull-ups and a register port on the same clock.
`timescale 1ns/10ps
module ims_controller (
	input logic clk,
	input logic srst,
	input logic [2:0] addr,
	input logic [7:0] wdata,
	input logic wr,
	input logic rd,
	output logic [7:0] rdata,
	output logic irq,
	input logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input logic port_scl_out,
	input logic port_scl_oe,
	input logic port_sda_out,
	input logic port_sda_oe
);
	ims_line_if ln ();
	logic [7:0] i2c_control;
	logic [7:0] next_ctrl;
	logic [7:0] shift_buffer;
	logic [7:0] own_slave_id;
	ims_pkg::ims_state_type st;
	ims_pkg::ims_state_type next_st;
	logic [3:0] bitcnt;
	logic [3:0] nb;
	logic [8:0] div_cnt;
	logic [8:0] half;
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic [3:0] irq_set;
	logic bus_port_on;
	logic ack_enable;
	logic tick;
	logic count_en;
	logic sda_pull;
	logic scl_pull;
	logic event_flag;
	logic stop_flag;
	logic gc_flag;
	logic busy;
	logic lost_flag;
	logic nack;
	logic tx_mode;
	logic slv;
	logic s_addr;
	logic master;
	logic wr_ctrl;
	logic rd_stat;
	logic sample;
	logic s_fall;
	logic byte_m;
	logic lost;
	logic start_go;
	logic hit;
	logic gc_hit;
	logic byte_s;
	logic stop_s;
	logic ev_set;

	ims_line_sense u_sense (
		.clk(clk),
		.srst(srst),
		.scl_pin(scl_in),
		.sda_pin(sda_in),
		.ln(ln)
	);

	// ----------------------------------------
	// Decode and timing
	// ----------------------------------------
	assign bus_port_on = i2c_control[ims_pkg::CB_EN];
	assign ack_enable = i2c_control[ims_pkg::CB_ACK];
	assign half = ims_pkg::half_period({i2c_control[ims_pkg::CB_RATE_HI],
		i2c_control[ims_pkg::CB_RATE_MID], i2c_control[ims_pkg::CB_RATE_LO]});
	// Phases with clock released wait for the line to go high: stretching
	assign count_en = ln.scl || !(st inside {ims_pkg::ST_MSTART, ims_pkg::ST_MHI,
		ims_pkg::ST_MRS2, ims_pkg::ST_MSTOP2, ims_pkg::ST_MSTOP3});
	assign tick = count_en && div_cnt == half - 9'h001;
	assign wr_ctrl = wr && addr == ims_pkg::REG_CTRL;
	assign rd_stat = rd && addr == ims_pkg::REG_STAT;
	assign master = st inside {ims_pkg::ST_MSTART, ims_pkg::ST_MLO, ims_pkg::ST_MHI,
		ims_pkg::ST_MWAIT, ims_pkg::ST_MRS1, ims_pkg::ST_MRS2, ims_pkg::ST_MSTOP1,
		ims_pkg::ST_MSTOP2, ims_pkg::ST_MSTOP3};

	// Bus events seen by master and slave sides
	assign s_fall = st == ims_pkg::ST_SBIT && ln.scl_fall;
	assign nb = bitcnt + 4'h1;
	assign sample = (st == ims_pkg::ST_MHI && tick) || (st == ims_pkg::ST_SBIT && ln.scl_rise);
	assign lost = st == ims_pkg::ST_MHI && tick && tx_mode && bitcnt < ims_pkg::BIT_ACK
		&& !sda_pull && !ln.sda;
	assign byte_m = st == ims_pkg::ST_MHI && tick && bitcnt == ims_pkg::BIT_ACK;
	assign gc_hit = shift_buffer == ims_pkg::BYTE_RESET && own_slave_id[ims_pkg::OWN_GC];
	assign hit = s_fall && s_addr && nb == ims_pkg::BIT_ACK && ack_enable
		&& (shift_buffer[7:1] == own_slave_id[7:1] || gc_hit);
	assign byte_s = s_fall && nb == ims_pkg::BIT_DONE && slv;
	assign stop_s = ln.stop_det && slv;
	assign ev_set = byte_m || lost || byte_s || stop_s;
	assign start_go = next_st == ims_pkg::ST_MSTART && st != ims_pkg::ST_MSTART;

	// Data line level for a slot: bits from the buffer, ack when receiving
	function automatic logic drive(input logic [3:0] idx, input logic tx,
		input logic msb, input logic ok);
		if (idx < ims_pkg::BIT_ACK) begin
			return tx && !msb;
		end
		return idx == ims_pkg::BIT_ACK && !tx && ok;
	endfunction : drive

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_st = st;
		case (st)
			ims_pkg::ST_IDLE: begin
				if (i2c_control[ims_pkg::CB_BEGIN] && !busy) begin
					next_st = ims_pkg::ST_MSTART;
				end else if (ln.start_det) begin
					next_st = ims_pkg::ST_SBIT;
				end
			end
			ims_pkg::ST_MSTART: if (tick) next_st = ims_pkg::ST_MLO;
			ims_pkg::ST_MLO: if (tick) next_st = ims_pkg::ST_MHI;
			ims_pkg::ST_MHI: begin
				if (lost) begin
					next_st = ims_pkg::ST_IDLE;
				end else if (tick) begin
					next_st = bitcnt == ims_pkg::BIT_ACK ? ims_pkg::ST_MWAIT : ims_pkg::ST_MLO;
				end
			end
			// Clock held low until the event is taken, then halt, restart or next byte
			ims_pkg::ST_MWAIT: begin
				if (!event_flag) begin
					if (i2c_control[ims_pkg::CB_HALT]) begin
						next_st = ims_pkg::ST_MSTOP1;
					end else if (i2c_control[ims_pkg::CB_BEGIN]) begin
						next_st = ims_pkg::ST_MRS1;
					end else begin
						next_st = ims_pkg::ST_MLO;
					end
				end
			end
			ims_pkg::ST_MRS1: if (tick) next_st = ims_pkg::ST_MRS2;
			ims_pkg::ST_MRS2: if (tick) next_st = ims_pkg::ST_MSTART;
			ims_pkg::ST_MSTOP1: if (tick) next_st = ims_pkg::ST_MSTOP2;
			ims_pkg::ST_MSTOP2: if (tick) next_st = ims_pkg::ST_MSTOP3;
			ims_pkg::ST_MSTOP3: if (tick) next_st = ims_pkg::ST_IDLE;
			ims_pkg::ST_SBIT: begin
				if (ln.stop_det) begin
					next_st = ims_pkg::ST_IDLE;
				end else if (s_fall && s_addr && nb == ims_pkg::BIT_ACK && !hit) begin
					next_st = ims_pkg::ST_SSKIP;
				end else if (byte_s) begin
					next_st = ims_pkg::ST_SWAIT;
				end
			end
			ims_pkg::ST_SWAIT: begin
				if (ln.stop_det) begin
					next_st = ims_pkg::ST_IDLE;
				end else if (!event_flag) begin
					next_st = (tx_mode && nack) ? ims_pkg::ST_SSKIP : ims_pkg::ST_SBIT;
				end
			end
			ims_pkg::ST_SSKIP: begin
				if (ln.stop_det) begin
					next_st = ims_pkg::ST_IDLE;
				end else if (ln.start_det) begin
					next_st = ims_pkg::ST_SBIT;
				end
			end
			default: next_st = ims_pkg::ST_IDLE;
		endcase
		if (!bus_port_on) begin
			next_st = ims_pkg::ST_IDLE;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= ims_pkg::ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Half-period divider, restarted at each phase change
	always_ff @(posedge clk) begin
		if (srst || next_st != st) begin
			div_cnt <= '0;
		end else if (count_en) begin
			div_cnt <= div_cnt + 9'h001;
		end
	end

	// Bit slot counter; the slave starts one below zero so the first fall gives 0
	always_ff @(posedge clk) begin
		if (srst) begin
			bitcnt <= ims_pkg::BIT_FIRST;
		end else if (ln.start_det && next_st == ims_pkg::ST_SBIT) begin
			bitcnt <= ims_pkg::BIT_PRE;
		end else if (next_st == ims_pkg::ST_MLO && st != ims_pkg::ST_MHI
			&& st != ims_pkg::ST_MLO) begin
			bitcnt <= ims_pkg::BIT_FIRST;
		end else if ((st == ims_pkg::ST_MHI && tick) || s_fall) begin
			bitcnt <= nb;
		end else if (st == ims_pkg::ST_SWAIT && next_st == ims_pkg::ST_SBIT) begin
			bitcnt <= ims_pkg::BIT_FIRST;
		end
	end

	// Address phase marker: first byte after any START
	always_ff @(posedge clk) begin
		if (srst) begin
			s_addr <= 1'b0;
		end else if (start_go || (ln.start_det && next_st == ims_pkg::ST_SBIT)) begin
			s_addr <= 1'b1;
		end else if (byte_m || (s_fall && nb == ims_pkg::BIT_DONE)) begin
			s_addr <= 1'b0;
		end
	end

	// ----------------------------------------
	// Data path and line drivers
	// ----------------------------------------
	// Shift toward the high end, so bit 7 leaves and arrives first
	always_ff @(posedge clk) begin
		if (srst) begin
			shift_buffer <= ims_pkg::BYTE_RESET;
		end else if (sample && bitcnt < ims_pkg::BIT_ACK) begin
			shift_buffer <= {shift_buffer[6:0], ln.sda};
		end else if (wr && addr == ims_pkg::REG_DATA) begin
			shift_buffer <= wdata;
		end
	end

	// Data pull changes only while the clock is low, except START and STOP
	always_ff @(posedge clk) begin
		if (srst) begin
			sda_pull <= 1'b0;
		end else if (next_st inside {ims_pkg::ST_IDLE, ims_pkg::ST_SSKIP,
			ims_pkg::ST_MRS1, ims_pkg::ST_MSTOP3}) begin
			sda_pull <= 1'b0;
		end else if (next_st inside {ims_pkg::ST_MSTART, ims_pkg::ST_MSTOP1}) begin
			sda_pull <= 1'b1;
		end else if (st == ims_pkg::ST_MLO && div_cnt == '0) begin
			sda_pull <= drive(bitcnt, tx_mode, shift_buffer[7], ack_enable);
		end else if (s_fall) begin
			sda_pull <= drive(nb, tx_mode, shift_buffer[7], s_addr ? hit : ack_enable);
		end else if (st == ims_pkg::ST_SWAIT && next_st == ims_pkg::ST_SBIT) begin
			sda_pull <= tx_mode && !shift_buffer[7];
		end
	end

	// Clock pulled low in master low phases and while a byte waits for software
	always_ff @(posedge clk) begin
		if (srst) begin
			scl_pull <= 1'b0;
		end else begin
			scl_pull <= next_st inside {ims_pkg::ST_MLO, ims_pkg::ST_MWAIT, ims_pkg::ST_MRS1,
				ims_pkg::ST_MSTOP1, ims_pkg::ST_SWAIT};
		end
	end

	// Disabled: port logic owns the pins and the core drivers float
	assign scl_oe = bus_port_on ? scl_pull : port_scl_oe;
	assign scl_out = bus_port_on ? 1'b0 : port_scl_out;
	assign sda_oe = bus_port_on ? sda_pull : port_sda_oe;
	assign sda_out = bus_port_on ? 1'b0 : port_sda_out;

	// ----------------------------------------
	// Control and status registers
	// ----------------------------------------
	// Hardware set of the address bit wins over a software clear
	always_comb begin
		next_ctrl = i2c_control;
		if (wr_ctrl) begin
			next_ctrl = wdata;
		end else begin
			if (start_go) next_ctrl[ims_pkg::CB_BEGIN] = 1'b0;
			if (ln.stop_det) next_ctrl[ims_pkg::CB_HALT] = 1'b0;
		end
		if (hit) begin
			next_ctrl[ims_pkg::CB_ADDR] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			i2c_control <= ims_pkg::CTRL_RESET;
			own_slave_id <= ims_pkg::BYTE_RESET;
		end else begin
			i2c_control <= next_ctrl;
			if (wr && addr == ims_pkg::REG_OWN) own_slave_id <= wdata;
		end
	end

	// Event flag: a new event beats the clearing read
	always_ff @(posedge clk) begin
		if (srst) begin
			event_flag <= 1'b0;
		end else if (ev_set) begin
			event_flag <= 1'b1;
		end else if (rd_stat) begin
			event_flag <= 1'b0;
		end
	end

	// Bus condition flags
	always_ff @(posedge clk) begin
		if (srst || !bus_port_on) begin
			busy <= 1'b0;
			stop_flag <= 1'b0;
			gc_flag <= 1'b0;
			slv <= 1'b0;
		end else if (ln.start_det || ln.stop_det) begin
			busy <= ln.start_det;
			stop_flag <= ln.stop_det;
			gc_flag <= 1'b0;
			slv <= 1'b0;
		end else if (hit) begin
			gc_flag <= gc_hit;
			slv <= 1'b1;
		end
	end

	// Role and transfer result flags
	always_ff @(posedge clk) begin
		if (srst) begin
			tx_mode <= 1'b0;
			lost_flag <= 1'b0;
			nack <= 1'b0;
		end else begin
			if (start_go) begin
				tx_mode <= 1'b1;
			end else if (ln.start_det && next_st == ims_pkg::ST_SBIT) begin
				tx_mode <= 1'b0;
			end else if ((byte_m && s_addr) || hit) begin
				tx_mode <= byte_m ? !shift_buffer[0] : shift_buffer[0];
			end
			if (lost) begin
				lost_flag <= 1'b1;
			end else if (start_go) begin
				lost_flag <= 1'b0;
			end
			if (sample && bitcnt == ims_pkg::BIT_ACK) begin
				nack <= ln.sda;
			end
		end
	end

	// Interrupt status: write one to clear, new events win
	assign irq_set[ims_pkg::IB_BYTE] = ev_set;
	assign irq_set[ims_pkg::IB_ADDR] = hit;
	assign irq_set[ims_pkg::IB_STOP] = stop_s;
	assign irq_set[ims_pkg::IB_LOST] = lost;
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_stat <= ims_pkg::IRQ_RESET;
			irq_mask <= ims_pkg::IRQ_RESET;
			irq <= 1'b0;
		end else begin
			if (wr && addr == ims_pkg::REG_ISTAT) begin
				irq_stat <= (irq_stat & ~wdata[3:0]) | irq_set;
			end else begin
				irq_stat <= irq_stat | irq_set;
			end
			if (wr && addr == ims_pkg::REG_IMASK) irq_mask <= wdata[3:0];
			irq <= |(irq_stat & irq_mask); // One cycle behind the status bits
		end
	end

	// Read data in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (srst || !rd) begin
			rdata <= ims_pkg::BYTE_RESET;
		end else begin
			case (addr)
				ims_pkg::REG_CTRL: rdata <= i2c_control;
				ims_pkg::REG_STAT: rdata <= {gc_flag, stop_flag, event_flag, tx_mode,
					busy && !master, lost_flag, nack, slv};
				ims_pkg::REG_DATA: rdata <= shift_buffer;
				ims_pkg::REG_OWN: rdata <= own_slave_id;
				ims_pkg::REG_ISTAT: rdata <= {4'h0, irq_stat};
				ims_pkg::REG_IMASK: rdata <= {4'h0, irq_mask};
				default: rdata <= ims_pkg::BYTE_RESET;
			endcase
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_halt_wait;
		st == ims_pkg::ST_MWAIT && i2c_control[ims_pkg::CB_HALT] && !event_flag && bus_port_on;
	endsequence
	sequence s_ack_end;
		st == ims_pkg::ST_MHI && tick && bitcnt == ims_pkg::BIT_ACK && bus_port_on;
	endsequence

	a_pins_to_port: assert property (
		!bus_port_on |-> sda_oe == port_sda_oe && scl_oe == port_scl_oe)
		else $error("port pins not handed to port logic");
	a_core_quiet: assert property (
		!bus_port_on |=> !sda_pull && !scl_pull && st == ims_pkg::ST_IDLE)
		else $error("core drives lines while disabled");
	a_begin_taken: assert property (
		(st == ims_pkg::ST_IDLE && bus_port_on && i2c_control[ims_pkg::CB_BEGIN] && !busy
		&& !wr_ctrl) |=> st == ims_pkg::ST_MSTART && sda_pull && !i2c_control[ims_pkg::CB_BEGIN])
		else $error("start not issued on free bus");
	a_halt_clear: assert property (
		(ln.stop_det && !wr_ctrl) |=> !i2c_control[ims_pkg::CB_HALT])
		else $error("halt request kept after stop");
	a_stop_after_wait: assert property (
		s_halt_wait |=> st == ims_pkg::ST_MSTOP1 && scl_pull && sda_pull)
		else $error("stop not begun after event period");
	a_addr_flag: assert property (
		hit |=> i2c_control[ims_pkg::CB_ADDR] && slv ##1 i2c_control[ims_pkg::CB_ADDR] || wr_ctrl)
		else $error("address flag not set by match");
	a_ack_level: assert property (
		(st == ims_pkg::ST_MLO && div_cnt == 9'h001 && bitcnt == ims_pkg::BIT_ACK && !tx_mode)
		|-> sda_pull == ack_enable)
		else $error("master receiver ack level wrong");
	a_byte_event: assert property (
		s_ack_end |=> event_flag && st == ims_pkg::ST_MWAIT && scl_pull)
		else $error("byte end without held event");
	a_read_clears: assert property (
		(rd_stat && !ev_set) |=> !event_flag)
		else $error("status read left event set");
	a_msb_first: assert property (
		(st == ims_pkg::ST_MLO && div_cnt == 9'h001 && bitcnt == ims_pkg::BIT_FIRST && tx_mode)
		|-> sda_pull == !shift_buffer[7])
		else $error("first bit is not bit 7");
	a_half_period: assert property (
		(st == ims_pkg::ST_MLO && tick) |-> {div_cnt, 1'b0} + 10'h002 == ims_pkg::OSC_DIV[
		{i2c_control[7], i2c_control[1], i2c_control[0]}])
		else $error("clock low phase not half the divisor");
endmodule : ims_controller

// file: ims_slave_model.sv
// Behavioural two-wire slave that stands at the far side of the controller.
// Assumes wire levels with pull-ups are worked out by the bench.
`timescale 1ns/10ps
module ims_slave_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_en,
	input wire logic [7:0] tx_byte,
	output logic sda_low,
	output logic [7:0] rx_byte,
	output logic master_ack
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00;
	logic rd_mode = 1'b0;
	logic first = 1'b0;
	initial sda_low = 1'b0;
	// START or STOP restarts the framing; data only moves while clock low
	always @(sda) if (scl) begin
		cnt = 4'h0;
		first = !sda;
		rd_mode = 1'b0;
		sda_low = 1'b0;
	end
	// Bits sampled on the rising clock, bit 7 first
	always @(posedge scl) begin
		if (cnt < 4'h8) sh = {sh[6:0], sda};
		else master_ack = !sda;
		cnt = cnt + 4'h1;
	end
	// Acknowledge, then read data; a nack from the master ends the read
	always @(negedge scl) begin
		if (cnt == 4'h8) begin
			rx_byte = sh;
			if (first) rd_mode = sh[0];
			sda_low = (first || !rd_mode) && ack_en;
		end else if (cnt == 4'h9) begin
			cnt = 4'h0;
			first = 1'b0;
			sda_low = 1'b0;
			rd_mode = rd_mode && master_ack;
		end
		if (rd_mode && !first && cnt < 4'h8) sda_low = !tx_byte[3'h7 - cnt[2:0]];
	end
endmodule : ims_slave_model

// file: ims_controller_tb_top.sv
// Register-level bench: master write, nack, STOP and master read transfers.
// Assumes the slave model as far side and pull-ups on both wires.
`timescale 1ns/10ps
module ims_controller_tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic p_sda_out = 1'b1;
	logic s_ack = 1'b1;
	logic [7:0] rdata, st, s_rx;
	logic irq, scl_out, scl_oe, sda_out, sda_oe, s_low, m_ack;
	logic [7:0] lo_n = 8'h00;
	logic [7:0] lo_w = 8'h00;
	int n_fail = 0;
	int samples_checked = 0;
	wire scl_w = !(scl_oe && !scl_out);
	wire sda_w = !((sda_oe && !sda_out) || s_low);
	initial forever #5 clk = !clk;
	ims_controller i_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
		.port_scl_out(1'b1), .port_scl_oe(1'b0), .port_sda_out(p_sda_out),
		.port_sda_oe(1'b1));
	ims_slave_model i_far (.scl(scl_w), .sda(sda_w), .ack_en(s_ack), .tx_byte(8'h5A),
		.sda_low(s_low), .rx_byte(s_rx), .master_ack(m_ack));
	// Width of the latest low phase on the clock wire
	always @(posedge clk) begin
		if (!scl_w) lo_n <= lo_n + 8'h01;
		else if (lo_n != 8'h00) begin
			lo_w <= lo_n;
			lo_n <= 8'h00;
		end
	end
	task automatic complete_run;
		$display("failures %0d of %0d checks", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic wait_irq;
		for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
		check("irq_raised", 8'h01, {7'h00, irq});
		if (irq !== 1'b1) complete_run();
	endtask : wait_irq
	// Halt set while the byte event is pending; the status read then releases into STOP
	task automatic stop_seq;
		wr_reg(3'h0, 8'h51);
		wr_reg(3'h4, 8'h01);
		rd_reg(3'h1, st);
		check("nack_seen", 8'h02, st & 8'h02);
		for (int i = 0; i < 300 && st[4] !== 1'b0; i++) rd_reg(3'h0, st);
		check("halt_clear", 8'h00, st & 8'h10);
		if (st[4] !== 1'b0) complete_run();
	endtask : stop_seq
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		check("port_oe", 8'h01, {7'h00, sda_oe});
		p_sda_out <= 1'b0;
		@(posedge clk);
		#1 check("port_out", 8'h00, {7'h00, sda_out});
		p_sda_out <= 1'b1;
		rd_reg(3'h0, st);
		check("ctrl_reset", 8'h00, st);
		wr_reg(3'h3, 8'hA5);
		rd_reg(3'h3, st);
		check("own_id", 8'hA5, st);
		rd_reg(3'h7, st);
		check("unmapped", 8'h00, st);
		wr_reg(3'h5, 8'h01);
		wr_reg(3'h2, 8'hA4);
		wr_reg(3'h0, 8'h41);
		check("idle_oe", 8'h00, {7'h00, scl_oe});
		wr_reg(3'h0, 8'h61);
		wait_irq();
		check("low_phase", 8'h01, {7'h00, lo_w == 8'd12 || lo_w == 8'd13});
		check("addr_byte", 8'hA4, s_rx);
		wr_reg(3'h5, 8'h00);
		repeat (3) @(posedge clk);
		check("irq_masked", 8'h00, {7'h00, irq});
		wr_reg(3'h5, 8'h01);
		repeat (3) @(posedge clk);
		check("irq_unmasked", 8'h01, {7'h00, irq});
		wr_reg(3'h2, 8'h3C);
		s_ack <= 1'b0;
		rd_reg(3'h1, st);
		check("stat_tx", 8'h30, st & 8'h33);
		rd_reg(3'h1, st);
		check("flag_cleared", 8'h00, st & 8'h20);
		wr_reg(3'h4, 8'h01);
		repeat (3) @(posedge clk);
		check("irq_w1c", 8'h00, {7'h00, irq});
		wait_irq();
		check("data_byte", 8'h3C, s_rx);
		stop_seq();
		s_ack <= 1'b1;
		wr_reg(3'h2, 8'hA5);
		wr_reg(3'h0, 8'h65);
		wait_irq();
		wr_reg(3'h4, 8'h01);
		rd_reg(3'h1, st);
		wait_irq();
		rd_reg(3'h2, st);
		check("rx_data", 8'h5A, st);
		check("master_ack", 8'h01, {7'h00, m_ack});
		wr_reg(3'h0, 8'h41);
		wr_reg(3'h4, 8'h01);
		rd_reg(3'h1, st);
		wait_irq();
		check("master_nack", 8'h00, {7'h00, m_ack});
		stop_seq();
		complete_run();
	end
endmodule : ims_controller_tb_top
